/* design/rcsm_pkg.sv */
// Shared constants for the reset cause, supply monitor and interrupt block
package rcsm_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_PC_MASK      = 6'h10;
  localparam logic [5:0] IDX_PC_FLAG      = 6'h11;
  localparam logic [5:0] IDX_PC_CTRL      = 6'h12;
  localparam logic [5:0] IDX_EXT_MASK     = 6'h13;
  localparam logic [5:0] IDX_EXT_FLAG     = 6'h14;
  localparam logic [5:0] IDX_EXT_SENSE    = 6'h15;
  localparam logic [5:0] IDX_SUPPLY_CTRL  = 6'h34;
  localparam logic [5:0] IDX_RESET_CAUSE  = 6'h3b;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SUPPLY_FLAG_BIT  = 7;
  localparam int SUPPLY_IE_BIT    = 6;
  localparam int WDT_CAUSE_BIT    = 3;
  localparam int PIN_CAUSE_BIT    = 1;
  localparam int POR_CAUSE_BIT    = 0;
  localparam int ENABLE_BIT       = 0;
  localparam int FLAG_BIT         = 0;

  // ---------------------------------------------------------------
  // Supply level select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] LVL_OFF   = 3'h0;
  localparam logic [2:0] LVL_RST_L = 3'h1;
  localparam logic [2:0] LVL_RST_H = 3'h2;
  localparam logic [2:0] LVL_IRQ_2 = 3'h3;
  localparam logic [2:0] LVL_IRQ_3 = 3'h4;

  // ---------------------------------------------------------------
  // External sense select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SENSE_LOW    = 2'h0;
  localparam logic [1:0] SENSE_CHANGE = 2'h1;
  localparam logic [1:0] SENSE_FALL   = 2'h2;
  localparam logic [1:0] SENSE_RISE   = 2'h3;

  // ---------------------------------------------------------------
  // Vector addresses
  // ---------------------------------------------------------------
  localparam int         VEC_W            = 4;
  localparam int         NUM_VEC          = 11;
  localparam logic [3:0] RESET_VECTOR     = 4'h0;
  localparam logic [3:0] EXT_IRQ_VECTOR   = 4'h1;
  localparam logic [3:0] PIN_CHANGE_VECTOR = 4'h2;
  localparam logic [3:0] TIMER_CAPTURE_VECTOR   = 4'h3;
  localparam logic [3:0] TIMER_OVERFLOW_VECTOR  = 4'h4;
  localparam logic [3:0] TIMER_COMPARE_A_VECTOR = 4'h5;
  localparam logic [3:0] TIMER_COMPARE_B_VECTOR = 4'h6;
  localparam logic [3:0] COMPARATOR_VECTOR      = 4'h7;
  localparam logic [3:0] WATCHDOG_VECTOR        = 4'h8;
  localparam logic [3:0] SUPPLY_MONITOR_VECTOR  = 4'h9;
  localparam logic [3:0] CONVERTER_VECTOR       = 4'ha;

  localparam logic [7:0] REG_ZERO = 8'h00;
endpackage : rcsm_pkg

/* design/irq_arb_if.sv */
// Carrier between the register block and the vector arbiter
`timescale 1ns/1ps
interface irq_arb_if;
  logic [rcsm_pkg::NUM_VEC-1:0] pending;
  logic                         global_enable;
  logic                         req;
  logic [rcsm_pkg::VEC_W-1:0]   vector;

  modport source (output pending, output global_enable,
                  input req, input vector);
  modport arbiter (input pending, input global_enable,
                   output req, output vector);
endinterface : irq_arb_if

/* design/irq_vector_arbiter.sv */
// Fixed priority vector arbiter: lowest vector address wins
`timescale 1ns/1ps
module irq_vector_arbiter (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pending requests and selected vector
  irq_arb_if.arbiter arb
);
  logic [rcsm_pkg::VEC_W-1:0] next_vector;
  logic                       any_pending;

  always_comb begin
    next_vector = rcsm_pkg::RESET_VECTOR;
    any_pending = 1'b0;
    // Scan downward so the lowest index is the last to win
    for (int i = rcsm_pkg::NUM_VEC - 1; i >= 1; i--) begin
      if (arb.pending[i]) begin
        next_vector = rcsm_pkg::VEC_W'(i);
        any_pending = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arb.req    <= 1'b0;
      arb.vector <= rcsm_pkg::RESET_VECTOR;
    end else begin
      arb.req    <= any_pending & arb.global_enable;
      arb.vector <= next_vector;
    end
  end
endmodule : irq_vector_arbiter

/* design/reset_cause_supply_monitor_irq.sv */
// Reset cause flags, supply monitor control and interrupt routing
`timescale 1ns/1ps

module reset_cause_supply_monitor_irq #(
  parameter int  PC_W          = 4,
  parameter bit  HAS_CONVERTER = 1'b1
) (
  // Clock and reset (reset is the power-on reset)
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Reset events and supply comparator
  input  wire logic        pin_reset_i,
  input  wire logic        watchdog_reset_i,
  input  wire logic        supply_below_i,
  output logic      [2:0]  supply_level_select_o,
  output logic             supply_reset_req_o,
  // External pins, sampled whatever their direction
  input  wire logic        ext_irq_pin_i,
  input  wire logic [PC_W-1:0] pin_change_inputs_i,
  output logic             wake_o,
  // Peripheral request levels
  input  wire logic        timer_capture_i,
  input  wire logic        timer_overflow_i,
  input  wire logic        timer_compare_a_i,
  input  wire logic        timer_compare_b_i,
  input  wire logic        comparator_i,
  input  wire logic        watchdog_irq_i,
  input  wire logic        converter_done_i,
  // Core side
  input  wire logic        global_irq_enable_i,
  input  wire logic        irq_ack_i,
  output logic             irq_req_o,
  output logic      [3:0]  irq_vector_o,
  output logic      [3:0]  reset_vector_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [2:0]      supply_level_select;
  logic            supply_monitor_irq_enable;
  logic            supply_monitor_flag;
  logic            watchdog_reset_cause;
  logic            pin_reset_cause;
  logic            power_on_reset_cause;
  logic [PC_W-1:0] pin_change_mask;
  logic            pin_change_irq_enable;
  logic            pin_change_flag;
  logic            ext_irq_enable;
  logic            ext_irq_flag;
  logic [1:0]      ext_sense_select;
  logic            ext_pin_q;
  logic [PC_W-1:0] pc_pins_q;
  logic [31:0]     rd_data;
  logic            ack;

  irq_arb_if arb ();

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire       bus_req  = wb_cyc_i & wb_stb_i & ~ack;
  wire       wr_lane  = bus_req & wb_we_i & wb_sel_i[0];
  wire [5:0] idx      = wb_adr_i[7:2];
  wire [7:0] wd       = wb_dat_i[7:0];
  wire       wr_pc_mask = wr_lane & (idx == rcsm_pkg::IDX_PC_MASK);
  wire       wr_pc_flag = wr_lane & (idx == rcsm_pkg::IDX_PC_FLAG);
  wire       wr_pc_ctrl = wr_lane & (idx == rcsm_pkg::IDX_PC_CTRL);
  wire       wr_ext_msk = wr_lane & (idx == rcsm_pkg::IDX_EXT_MASK);
  wire       wr_ext_flg = wr_lane & (idx == rcsm_pkg::IDX_EXT_FLAG);
  wire       wr_ext_sns = wr_lane & (idx == rcsm_pkg::IDX_EXT_SENSE);
  wire       wr_supply  = wr_lane & (idx == rcsm_pkg::IDX_SUPPLY_CTRL);
  wire       wr_cause   = wr_lane & (idx == rcsm_pkg::IDX_RESET_CAUSE);

  // ---------------------------------------------------------------
  // Supply monitor
  // ---------------------------------------------------------------
  wire lvl_irq_mode = (supply_level_select == rcsm_pkg::LVL_IRQ_2) |
                      (supply_level_select == rcsm_pkg::LVL_IRQ_3);
  wire lvl_rst_mode = (supply_level_select == rcsm_pkg::LVL_RST_L) |
                      (supply_level_select == rcsm_pkg::LVL_RST_H);
  // Forbidden codes leave the monitor inert, neither reset nor flag
  wire supply_set   = lvl_irq_mode & supply_below_i;
  wire supply_clr   = ~supply_below_i |
                      (wr_supply & (wd[2:0] == rcsm_pkg::LVL_OFF));
  wire next_supply_flag = supply_set | (supply_monitor_flag & ~supply_clr);

  assign supply_reset_req_o    = lvl_rst_mode & supply_below_i;
  assign supply_level_select_o = supply_level_select;

  // ---------------------------------------------------------------
  // External pin and pin change detection
  // ---------------------------------------------------------------
  wire ext_level_mode = (ext_sense_select == rcsm_pkg::SENSE_LOW);
  wire ext_rise = ext_irq_pin_i & ~ext_pin_q;
  wire ext_fall = ~ext_irq_pin_i & ext_pin_q;
  logic ext_edge;
  always_comb begin
    case (ext_sense_select)
      rcsm_pkg::SENSE_CHANGE: ext_edge = ext_rise | ext_fall;
      rcsm_pkg::SENSE_FALL:   ext_edge = ext_fall;
      rcsm_pkg::SENSE_RISE:   ext_edge = ext_rise;
      default:                ext_edge = 1'b0;
    endcase
  end

  wire ack_ext = irq_ack_i & (irq_vector_o == rcsm_pkg::EXT_IRQ_VECTOR);
  wire ack_pc  = irq_ack_i & (irq_vector_o == rcsm_pkg::PIN_CHANGE_VECTOR);
  wire ext_clr = ack_ext | (wr_ext_flg & wd[rcsm_pkg::FLAG_BIT]);
  wire pc_clr  = ack_pc | (wr_pc_flag & wd[rcsm_pkg::FLAG_BIT]);
  // Set wins over clear so a coincident edge is not lost
  wire next_ext_flag = ~ext_level_mode &
                       (ext_edge | (ext_irq_flag & ~ext_clr));
  wire [PC_W-1:0] pc_toggle = (pin_change_inputs_i ^ pc_pins_q) &
                              pin_change_mask;
  wire next_pc_flag = (|pc_toggle) | (pin_change_flag & ~pc_clr);

  // Level request follows the live pin, so a level gone before
  // start-up ends leaves nothing pending after wake-up
  wire ext_level_req = ext_level_mode & ~ext_irq_pin_i;

  // Asynchronous wake paths need no clock edge
  assign wake_o = (ext_irq_enable & ext_level_req) |
                  (pin_change_irq_enable & (|pc_toggle));

  // ---------------------------------------------------------------
  // Vector requests
  // ---------------------------------------------------------------
  logic [rcsm_pkg::NUM_VEC-1:0] pending;
  always_comb begin
    pending = '0;
    pending[rcsm_pkg::EXT_IRQ_VECTOR] = ext_irq_enable &
      (ext_irq_flag | ext_level_req);
    pending[rcsm_pkg::PIN_CHANGE_VECTOR] = pin_change_irq_enable &
      pin_change_flag;
    pending[rcsm_pkg::TIMER_CAPTURE_VECTOR]   = timer_capture_i;
    pending[rcsm_pkg::TIMER_OVERFLOW_VECTOR]  = timer_overflow_i;
    pending[rcsm_pkg::TIMER_COMPARE_A_VECTOR] = timer_compare_a_i;
    pending[rcsm_pkg::TIMER_COMPARE_B_VECTOR] = timer_compare_b_i;
    pending[rcsm_pkg::COMPARATOR_VECTOR]      = comparator_i;
    pending[rcsm_pkg::WATCHDOG_VECTOR]        = watchdog_irq_i;
    pending[rcsm_pkg::SUPPLY_MONITOR_VECTOR]  =
      supply_monitor_irq_enable & supply_monitor_flag;
    pending[rcsm_pkg::CONVERTER_VECTOR] = HAS_CONVERTER &
      converter_done_i;
  end

  assign arb.pending       = pending;
  assign arb.global_enable = global_irq_enable_i;
  assign irq_req_o         = arb.req;
  assign irq_vector_o      = arb.vector;
  assign reset_vector_o    = rcsm_pkg::RESET_VECTOR;

  irq_vector_arbiter u_arb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .arb   (arb)
  );

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  wire [7:0] rd_supply = {supply_monitor_flag, supply_monitor_irq_enable,
                          3'h0, supply_level_select};
  wire [7:0] rd_cause  = {4'h0, watchdog_reset_cause, 1'b0,
                          pin_reset_cause, power_on_reset_cause};
  always_comb begin
    rd_data = '0;
    if (idx == rcsm_pkg::IDX_PC_MASK) begin
      rd_data[PC_W-1:0] = pin_change_mask;
    end else if (idx == rcsm_pkg::IDX_PC_FLAG) begin
      rd_data[rcsm_pkg::FLAG_BIT] = pin_change_flag;
    end else if (idx == rcsm_pkg::IDX_PC_CTRL) begin
      rd_data[rcsm_pkg::ENABLE_BIT] = pin_change_irq_enable;
    end else if (idx == rcsm_pkg::IDX_EXT_MASK) begin
      rd_data[rcsm_pkg::ENABLE_BIT] = ext_irq_enable;
    end else if (idx == rcsm_pkg::IDX_EXT_FLAG) begin
      rd_data[rcsm_pkg::FLAG_BIT] = ext_irq_flag;
    end else if (idx == rcsm_pkg::IDX_EXT_SENSE) begin
      rd_data[1:0] = ext_sense_select;
    end else if (idx == rcsm_pkg::IDX_SUPPLY_CTRL) begin
      rd_data[7:0] = rd_supply;
    end else if (idx == rcsm_pkg::IDX_RESET_CAUSE) begin
      rd_data[7:0] = rd_cause;
    end
  end

  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack      <= bus_req;
      wb_dat_o <= bus_req ? rd_data : '0;
    end
  end
  assign wb_ack_o = ack;

  // ---------------------------------------------------------------
  // Reset cause flags
  // ---------------------------------------------------------------
  // Block reset stands for the power-on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_on_reset_cause <= 1'b1;
      pin_reset_cause      <= 1'b0;
      watchdog_reset_cause <= 1'b0;
    end else begin
      power_on_reset_cause <= power_on_reset_cause &
        ~(wr_cause & ~wd[rcsm_pkg::POR_CAUSE_BIT]);
      pin_reset_cause <= pin_reset_i | (pin_reset_cause &
        ~(wr_cause & ~wd[rcsm_pkg::PIN_CAUSE_BIT]));
      watchdog_reset_cause <= watchdog_reset_i | (watchdog_reset_cause &
        ~(wr_cause & ~wd[rcsm_pkg::WDT_CAUSE_BIT]));
    end
  end

  // ---------------------------------------------------------------
  // Control registers and flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_level_select       <= rcsm_pkg::LVL_OFF;
      supply_monitor_irq_enable <= 1'b0;
      pin_change_mask           <= '0;
      pin_change_irq_enable     <= 1'b0;
      ext_irq_enable            <= 1'b0;
      ext_sense_select          <= rcsm_pkg::SENSE_LOW;
    end else begin
      if (wr_supply) begin
        supply_level_select       <= wd[2:0];
        supply_monitor_irq_enable <= wd[rcsm_pkg::SUPPLY_IE_BIT];
      end
      if (wr_pc_mask) begin
        pin_change_mask <= wd[PC_W-1:0];
      end
      if (wr_pc_ctrl) begin
        pin_change_irq_enable <= wd[rcsm_pkg::ENABLE_BIT];
      end
      if (wr_ext_msk) begin
        ext_irq_enable <= wd[rcsm_pkg::ENABLE_BIT];
      end
      if (wr_ext_sns) begin
        ext_sense_select <= wd[1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_monitor_flag <= 1'b0;
      ext_irq_flag        <= 1'b0;
      pin_change_flag     <= 1'b0;
      ext_pin_q           <= 1'b1;
      pc_pins_q           <= '0;
    end else begin
      supply_monitor_flag <= next_supply_flag;
      ext_irq_flag        <= next_ext_flag;
      pin_change_flag     <= next_pc_flag;
      ext_pin_q           <= ext_irq_pin_i;
      pc_pins_q           <= pin_change_inputs_i;
    end
  end
endmodule : reset_cause_supply_monitor_irq

/* verif/reset_cause_supply_monitor_irq_monitor.sv */
// Port-level checks for the reset cause, supply and interrupt block
`timescale 1ns/1ps
module reset_cause_supply_monitor_irq_monitor (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Register bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Supply monitor
  input wire logic       supply_below_i,
  input wire logic [2:0] supply_level_select_o,
  input wire logic       supply_reset_req_o,
  // Requests and core side
  input wire logic       timer_capture_i,
  input wire logic       converter_done_i,
  input wire logic       global_irq_enable_i,
  input wire logic       irq_req_o,
  input wire logic [3:0] irq_vector_o,
  input wire logic [3:0] reset_vector_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // -----------------------------------------------------------------
  // Bus timing
  // -----------------------------------------------------------------
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  // -----------------------------------------------------------------
  // Supply monitor and vectors
  // -----------------------------------------------------------------
  supply_reset_a: assert property (
      supply_reset_req_o == (supply_below_i &&
      (supply_level_select_o == 3'h1 || supply_level_select_o == 3'h2)))
    else $error("supply reset request mismatch");
  select_write_a: assert property (
      $changed(supply_level_select_o) |-> wb_ack_o)
    else $error("level select moved without a write");
  reset_vector_a: assert property (reset_vector_o == 4'h0)
    else $error("reset vector not zero");
  capture_src_a: assert property (
      irq_req_o && irq_vector_o == 4'h3 |-> $past(timer_capture_i))
    else $error("capture vector without request");
  converter_src_a: assert property (
      irq_req_o && irq_vector_o == 4'ha |-> $past(converter_done_i))
    else $error("converter vector without request");
  // Antecedent excludes the reset edge, where outputs are still cleared
  priority_low_a: assert property ($past(timer_capture_i &&
      global_irq_enable_i && !rst_i) |-> irq_req_o && irq_vector_o <= 4'h3)
    else $error("lower vector not served first");
  global_gate_a: assert property (!global_irq_enable_i &&
      !$past(global_irq_enable_i) |-> !irq_req_o)
    else $error("request while globally disabled");
endmodule : reset_cause_supply_monitor_irq_monitor

/* verif/core_model.sv */
// Behavioural processor core that takes interrupt vectors
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Controls from the bench
  input  wire logic       serve_i,
  input  wire logic       slow_i,
  // Request from the block
  input  wire logic       irq_req_i,
  input  wire logic [3:0] irq_vector_i,
  // Acknowledge back
  output logic            irq_ack_o,
  output logic      [3:0] taken_vector_o
);
  logic [1:0] wait_cnt;
  logic       go;
  logic       ack_q;
  // Slow mode models a core finishing a long instruction first
  // Request still stands the cycle after a take, so skip that cycle
  assign go = serve_i && irq_req_i && !irq_ack_o && !ack_q &&
              (!slow_i || &wait_cnt);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ack_o      <= 1'b0;
      taken_vector_o <= 4'h0;
      wait_cnt       <= 2'h0;
      ack_q          <= 1'b0;
    end else begin
      wait_cnt  <= wait_cnt + 2'h1;
      ack_q     <= irq_ack_o;
      irq_ack_o <= go;
      if (go) taken_vector_o <= irq_vector_i;
    end
  end
endmodule : core_model

/* verif/reset_cause_supply_monitor_irq_bench.sv */
// Self-checking bench for the reset cause, supply and interrupt block
`timescale 1ns/1ps
module reset_cause_supply_monitor_irq_bench;
  logic        clk_i, rst_i, req, we, wb_ack_o, below, sup_rst, pin, wake;
  logic        gie, ack, irq_req, serve, slow;
  logic [7:0]  adr;
  logic [31:0] wdat, wb_dat_o, rd;
  logic [1:0]  rst_ev;
  logic [2:0]  sel_o;
  logic [3:0]  pc, irq_vec, rvec, taken, msk, nv, old;
  logic [6:0]  per, pv;
  integer      seed = 32'h37187896;
  int          num_errors = 0;
  int          checked = 0;
  reset_cause_supply_monitor_irq #(.PC_W(4), .HAS_CONVERTER(1'b1)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_reset_i(rst_ev[0]),
    .watchdog_reset_i(rst_ev[1]), .supply_below_i(below),
    .supply_level_select_o(sel_o), .supply_reset_req_o(sup_rst),
    .ext_irq_pin_i(pin), .pin_change_inputs_i(pc), .wake_o(wake),
    .timer_capture_i(per[0]), .timer_overflow_i(per[1]),
    .timer_compare_a_i(per[2]), .timer_compare_b_i(per[3]),
    .comparator_i(per[4]), .watchdog_irq_i(per[5]),
    .converter_done_i(per[6]), .global_irq_enable_i(gie),
    .irq_ack_i(ack), .irq_req_o(irq_req), .irq_vector_o(irq_vec),
    .reset_vector_o(rvec));
  core_model core (.clk_i(clk_i), .rst_i(rst_i), .serve_i(serve),
    .slow_i(slow), .irq_req_i(irq_req), .irq_vector_i(irq_vec),
    .irq_ack_o(ack), .taken_vector_o(taken));
  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    q = wb_dat_o;
    req <= 1'b0;
    we  <= 1'b0;
  endtask : bus
  task automatic pulse_ev(input logic [1:0] v);
    @(posedge clk_i);
    rst_ev <= v;
    @(posedge clk_i);
    rst_ev <= 2'b00;
  endtask : pulse_ev
  function automatic logic exp_ext(input int s, input logic o, n);
    case (s)
      1: exp_ext = o != n;
      2: exp_ext = o && !n;
      3: exp_ext = !o && n;
      default: exp_ext = 1'b0;
    endcase
  endfunction : exp_ext
  function automatic logic [3:0] exp_vec(input logic [6:0] p);
    exp_vec = 4'h0;
    for (int i = 6; i >= 0; i--)
      if (p[i]) exp_vec = i == 6 ? 4'ha : 4'(i + 3);
  endfunction : exp_vec
  // -----------------------------------------------------------------
  // Stimulus
  // -----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #(5 * 20000);
    num_errors++;
    wrap_up();
  end
  initial begin
    {rst_i, req, we, adr, wdat, rst_ev} = {1'b1, 44'h0};
    {below, pin, pc, per, gie, serve, slow} = {2'b01, 11'h0, 3'b100};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, 8'hec, 0, rd); check(rd, 32'h1);
    bus(0, 8'h00, 0, rd); check(rd, 32'h0);
    check(rvec, 4'h0);
    bus(1, 8'hec, 8'h00, rd);
    bus(0, 8'hec, 0, rd); check(rd, 32'h0);
    pulse_ev(2'b10);
    bus(0, 8'hec, 0, rd); check(rd, 32'h8);
    pulse_ev(2'b01);
    bus(0, 8'hec, 0, rd); check(rd, 32'ha);
    bus(1, 8'hec, 8'h08, rd);
    bus(0, 8'hec, 0, rd); check(rd, 32'h8);
    for (int c = 0; c < 5; c++) begin
      bus(1, 8'hd0, 8'h40 | 8'(c), rd);
      below <= 1'b1;
      repeat (3) @(posedge clk_i);
      check(sup_rst, c == 1 || c == 2);
      check(irq_req, c > 2);
      check(irq_vec, c > 2 ? 4'h9 : 4'h0);
      bus(0, 8'hd0, 0, rd);
      check(rd, 8'h40 | 8'(c) | (c > 2 ? 8'h80 : 8'h00));
      below <= 1'b0;
      repeat (3) @(posedge clk_i);
      bus(0, 8'hd0, 0, rd); check(rd, 8'h40 | 8'(c));
    end
    bus(1, 8'hd0, 8'h00, rd); check(sel_o, 3'h0);
    serve <= 1'b0;
    bus(1, 8'h4c, 8'h01, rd);
    for (int s = 1; s < 4; s++) begin
      bus(1, 8'h54, 8'(s), rd);
      repeat (6) begin
        old = {3'h0, pin};
        nv = 4'($random(seed));
        pin <= nv[0];
        repeat (3) @(posedge clk_i);
        bus(0, 8'h50, 0, rd);
        check(rd, exp_ext(s, old[0], nv[0]));
        bus(1, 8'h50, 8'h01, rd);
      end
    end
    bus(1, 8'h54, 8'h00, rd);
    pin <= 1'b0;
    repeat (12) @(posedge clk_i);
    check({wake, irq_req, irq_vec}, 6'h31);
    bus(0, 8'h50, 0, rd); check(rd, 32'h0);
    pin <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(irq_req, 1'b0);
    bus(1, 8'h54, 8'h02, rd);
    {serve, slow, pin} <= 3'b110;
    repeat (12) @(posedge clk_i);
    check(taken, 4'h1);
    bus(0, 8'h50, 0, rd); check(rd, 32'h0);
    serve <= 1'b0;
    bus(1, 8'h48, 8'h01, rd);
    repeat (8) begin
      msk = 4'($random(seed));
      nv = 4'($random(seed));
      bus(1, 8'h40, {4'h0, msk}, rd);
      old = pc;
      pc <= nv;
      repeat (3) @(posedge clk_i);
      check(irq_vec, |((old ^ nv) & msk) ? 4'h2 : 4'h0);
      bus(0, 8'h44, 0, rd); check(rd, |((old ^ nv) & msk));
      bus(1, 8'h44, 8'h01, rd);
    end
    repeat (20) begin
      pv = 7'($random(seed));
      @(posedge clk_i);
      per <= pv;
      repeat (2) @(posedge clk_i);
      check(irq_req, |pv);
      check(irq_vec, exp_vec(pv));
    end
    gie <= 1'b0;
    per <= 7'h7f;
    repeat (3) @(posedge clk_i);
    check(irq_req, 1'b0);
    wrap_up();
  end
endmodule : reset_cause_supply_monitor_irq_bench

bind reset_cause_supply_monitor_irq reset_cause_supply_monitor_irq_monitor mon (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .supply_below_i,
  .supply_level_select_o, .supply_reset_req_o, .timer_capture_i,
  .converter_done_i, .global_irq_enable_i, .irq_req_o, .irq_vector_o,
  .reset_vector_o);
